// ---- dv/sso_speech_out_properties.sv ----
/*
  concurrent checks on the ports of the speech sample output bank.
  assumes: one aclk domain; the bench offers write address and data together.
*/
`timescale 1ns/1ns
module sso_speech_out_props import sso_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // timing pins and outputs
  input wire logic second_timer_clk,
  input wire logic external_sample_sync,
  input wire logic [SSO_SAMPLE_W-1:0] converter_data,
  input wire logic [SSO_DIG_W-1:0] digital_out,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic clr_reg;

  // remember whether the write in flight clears the whole status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_reg <= 1'b0;
    end else if (awvalid && awready) begin
      clr_reg <= (awaddr == {SSO_REGION_TAG, SSO_OFF_STAT}) && (wdata[1:0] == 2'b00);
    end
  end

  ////////////////////
  property p_wr_lat;
    awvalid && awready && wvalid && wready |=> !bvalid ##3 $rose(bvalid);
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer off the access time");
  property p_rd_lat;
    arvalid && arready |=> !rvalid ##3 $rose(rvalid);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer off the access time");
  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
  property p_rd_upper;
    rvalid |-> rdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
  property p_conv_cause;
    $changed(converter_data) |-> $past(second_timer_clk, 2);
  endproperty
  a_conv_cause: assert property (p_conv_cause) else $error("converter input moved without a tick");
  property p_dig_cause;
    $changed(digital_out) |-> $past(external_sample_sync, 2);
  endproperty
  a_dig_cause: assert property (p_dig_cause) else $error("digital output moved without a sync");
  property p_clr_irq;
    $rose(bvalid) && clr_reg |-> ##[1:2] !irq;
  endproperty
  a_clr_irq: assert property (p_clr_irq) else $error("interrupt kept after status clear");
  property p_b_ready;
    bvalid && bready |=> awready && wready;
  endproperty
  a_b_ready: assert property (p_b_ready) else $error("write channels not reopened");
  property p_rd_refuse;
    rvalid |-> !arready;
  endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("second read taken while pending");

  // main scenarios reached
  c_wr: cover property (bvalid && bready);
  c_conv: cover property ($changed(converter_data));
  c_dig: cover property ($changed(digital_out));
  c_irq: cover property ($rose(irq));
endmodule

bind sso_speech_out sso_speech_out_props i_props (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
  .wdata, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .second_timer_clk, .external_sample_sync,
  .converter_data, .digital_out, .irq);

// ---- dv/sso_speech_out_tb.sv ----
/*
  self-checking bench for the speech sample output bank: register map,
  converter and digital paths, interrupt status, mask and legacy mode.
  assumes: sso_pkg, the timer model and the checker are compiled first.
*/
`timescale 1ns/1ns
module sso_speech_out_tb;
  import sso_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, va, vb, vc, vd;
  logic awready, wready, bvalid, arready, rvalid, irq, stc, sti, ess;
  logic run_clk = 1'b0, run_sync = 1'b0;
  logic [1:0] bresp, rresp;
  logic [11:0] converter_data;
  logic [15:0] digital_out;
  logic [7:0] offs [7] = '{SSO_OFF_HOLD_A, SSO_OFF_HOLD_B, SSO_OFF_SCRATCH, SSO_OFF_CMD, SSO_OFF_DIG_A,
    SSO_OFF_DIG_B, SSO_OFF_MASK};
  int err_total = 0, tests_run = 0;

  // 250 MHz clock
  always #2 aclk = ~aclk;

  sso_speech_out i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
    .rresp, .second_timer_clk(stc), .second_timer_irq(sti), .external_sample_sync(ess), .converter_data,
    .digital_out, .irq);
  sso_timer_model i_timer (.aclk, .run_clk, .run_sync, .second_timer_clk(stc), .second_timer_irq(sti),
    .external_sample_sync(ess));

  ////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] ad(input logic [7:0] off);
    ad = {SSO_REGION_TAG, off};
  endfunction

  // bits a register keeps; everything else reads zero
  function automatic logic [31:0] field_of(input logic [7:0] off);
    case (off)
      SSO_OFF_HOLD_A, SSO_OFF_HOLD_B: field_of = 32'h0000_0fff;
      SSO_OFF_SCRATCH, SSO_OFF_MASK: field_of = 32'h0000_0003;
      SSO_OFF_CMD: field_of = 32'h0000_0007;
      default: field_of = 32'h0000_ffff;
    endcase
  endfunction

  // address and data offered together, each dropped once its ready is seen
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ap, dp;
    ap = 1'b1;
    dp = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ap || dp) begin
      @(posedge aclk);
      if (ap && awready) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (dp && wready) begin
        wvalid <= 1'b0;
        dp = 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, exp);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  // wait for one tick and let the synchroniser and loader settle
  task automatic tick(input logic dig);
    if (dig) @(posedge ess);
    else @(posedge stc);
    repeat (8) @(posedge aclk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h8b44_5e07));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("conv", 32'(converter_data), 32'h0);
    chk("dig", 32'(digital_out), 32'h0);
    for (int i = 0; i <= 8; i++) begin
      rd(ad(8'(i * 4)), 32'h0, SSO_RESP_OKAY);
    end
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 3; j++) begin
        va = (j == 0) ? 32'hffff_ffff : $urandom();
        wr(ad(offs[i]), va, SSO_RESP_OKAY);
        rd(ad(offs[i]), va & field_of(offs[i]), SSO_RESP_OKAY);
      end
    end
    wr(ad(SSO_OFF_CONV), 32'hffff_ffff, SSO_RESP_OKAY);
    rd(ad(SSO_OFF_CONV), 32'h0, SSO_RESP_OKAY);
    wr(ad(8'h24), 32'h1, SSO_RESP_SLVERR);
    rd(ad(8'hfc), 32'h0, SSO_RESP_SLVERR);
    wr(32'h9000_0000, 32'h3, SSO_RESP_DECERR);
    rd(32'h0000_0010, 32'h0, SSO_RESP_DECERR);
    // converter path: second holding register first, then four ticks
    wr(ad(SSO_OFF_CMD), 32'h0, SSO_RESP_OKAY);
    wr(ad(SSO_OFF_MASK), 32'h3, SSO_RESP_OKAY);
    va = $urandom();
    vb = $urandom();
    wr(ad(SSO_OFF_HOLD_B), vb, SSO_RESP_OKAY);
    wr(ad(SSO_OFF_HOLD_A), va, SSO_RESP_OKAY);
    run_clk <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tick(1'b0);
      chk("conv", 32'(converter_data), ((i % 2) == 0 ? va : vb) & 32'h0000_0fff);
      chk("irq", 32'(irq), 32'(i > 0));
    end
    run_clk <= 1'b0;
    rd(ad(SSO_OFF_STAT), 32'h1, SSO_RESP_OKAY);
    wr(ad(SSO_OFF_MASK), 32'h0, SSO_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    wr(ad(SSO_OFF_MASK), 32'h3, SSO_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'h1);
    wr(ad(SSO_OFF_STAT), 32'h2, SSO_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    rd(ad(SSO_OFF_STAT), 32'h0, SSO_RESP_OKAY);
    // digital path with its interrupt enabled, then suppressed
    for (int e = 1; e >= 0; e--) begin
      wr(ad(SSO_OFF_CMD), (e != 0) ? 32'h6 : 32'h2, SSO_RESP_OKAY);
      vc = $urandom();
      vd = $urandom();
      wr(ad(SSO_OFF_DIG_B), vd, SSO_RESP_OKAY);
      wr(ad(SSO_OFF_DIG_A), vc, SSO_RESP_OKAY);
      run_sync <= 1'b1;
      for (int i = 0; i < 2; i++) begin
        tick(1'b1);
        chk("dig", 32'(digital_out), ((i == 0) ? vc : vd) & 32'h0000_ffff);
      end
      run_sync <= 1'b0;
      chk("conv", 32'(converter_data), vb & 32'h0000_0fff);
      chk("irq", 32'(irq), 32'(e));
      rd(ad(SSO_OFF_STAT), (e != 0) ? 32'h2 : 32'h0, SSO_RESP_OKAY);
      wr(ad(SSO_OFF_STAT), 32'h0, SSO_RESP_OKAY);
    end
    // legacy mode: timer interrupt passes straight through, mask ignored
    wr(ad(SSO_OFF_MASK), 32'h0, SSO_RESP_OKAY);
    wr(ad(SSO_OFF_CMD), 32'h1, SSO_RESP_OKAY);
    run_clk <= 1'b1;
    @(posedge sti);
    repeat (8) @(posedge aclk);
    chk("irq", 32'(irq), 32'h1);
    rd(ad(SSO_OFF_STAT), 32'h1, SSO_RESP_OKAY);
    @(negedge sti);
    repeat (8) @(posedge aclk);
    run_clk <= 1'b0;
    chk("irq", 32'(irq), 32'h0);
    rd(ad(SSO_OFF_STAT), 32'h0, SSO_RESP_OKAY);
    complete_run();
  end

  // the run needs under a thousand cycles; a hang ends here
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run();
  end
endmodule

// ---- dv/sso_timer_model.sv ----
/*
  model of the second timer in divided-clock mode and of the external sync
  source that drive the sample bank's timing pins.
  assumes: the bench raises one run control at a time; both lines stand low
  while stopped.
*/
`timescale 1ns/1ns
module sso_timer_model #(
  parameter int HALF = 20
) (
  // clock
  input wire logic aclk,
  // run controls from the bench
  input wire logic run_clk,
  input wire logic run_sync,
  // timing pins
  output logic second_timer_clk,
  output logic second_timer_irq,
  output logic external_sample_sync
);
  int cnt = 0;
  logic sq = 1'b0;

  // 50 percent duty square wave, restarted from low so no runt pulse appears
  always_ff @(posedge aclk) begin
    if (!run_clk && !run_sync) begin
      cnt <= 0;
      sq <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      sq <= !sq;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // the timer interrupt simply follows its divided clock level
  assign second_timer_clk = run_clk & sq;
  assign second_timer_irq = run_clk & sq;
  assign external_sample_sync = run_sync & sq;
endmodule

// ---- include/sso_pkg.sv ----
/*
  constants, field layouts and carrier types for the speech sample output
  register bank.
  assumes: a single 250 MHz clock domain and a 32-bit axi4-lite register bus;
  the timer that makes the sample clock lives outside this bank.
*/
// How it works
// - two sample holding registers keep 12 data bits in the low positions, read zero above, and clear at reset.
// - a separate conversion register holds the sample now fed to the converter and clears at reset.
// - writing a zero to a status bit drops that pending interrupt, and software acknowledges that way.
// - in legacy mode the status register clears by itself when the second timer drops its interrupt.
// - status bit 1 flags an interrupt raised while the digital output path is in use.
// - status bit 0 flags an interrupt raised while samples go out through the converter path.
// - a general scratch register holds two user bits, has no hardware effect and resets to zero.
// - command bit 2 lets digital path interrupts through when one and suppresses them when zero.
// - command bit 1 picks the converter path when zero and the 16-bit digital output when one.
// - command bit 0 turns on the legacy compatibility mode.
// - all registers decode inside the region at 0x8000_0000 and every access there takes three cycles.
// - the converter input changes only once per sample period, so the analog output is a staircase.
// - each sample tick loads the conversion register from the two holding registers in turn.
// - the sample clock is the second timer's divided clock and, outside legacy mode, converter path interrupts come at half its rate.
// - in digital mode the 16-bit output takes from the two digital holding registers in turn on the sync.
package sso_pkg;

  // region decode
  localparam logic [31:0] SSO_BASE_ADDR = 32'h8000_0000;
  localparam logic [23:0] SSO_REGION_TAG = SSO_BASE_ADDR[31:8];

  // register byte offsets inside the region
  localparam logic [7:0] SSO_OFF_HOLD_A = 8'h00;
  localparam logic [7:0] SSO_OFF_HOLD_B = 8'h04;
  localparam logic [7:0] SSO_OFF_CONV = 8'h08;
  localparam logic [7:0] SSO_OFF_STAT = 8'h0C;
  localparam logic [7:0] SSO_OFF_SCRATCH = 8'h10;
  localparam logic [7:0] SSO_OFF_CMD = 8'h14;
  localparam logic [7:0] SSO_OFF_DIG_A = 8'h18;
  localparam logic [7:0] SSO_OFF_DIG_B = 8'h1C;
  localparam logic [7:0] SSO_OFF_MASK = 8'h20;

  // field widths
  localparam int SSO_SAMPLE_W = 12;
  localparam int SSO_DIG_W = 16;
  localparam int SSO_SCRATCH_W = 2;

  // reset values
  localparam logic [11:0] SSO_SAMPLE_RST = 12'h000;
  localparam logic [15:0] SSO_DIG_RST = 16'h0000;
  localparam logic [1:0] SSO_SCRATCH_RST = 2'h0;
  localparam logic [2:0] SSO_CMD_RST = 3'h0;
  localparam logic [1:0] SSO_STAT_RST = 2'h0;
  localparam logic [1:0] SSO_MASK_RST = 2'h0;

  // access timing: answer three cycles after the request is taken
  localparam int SSO_ACCESS_CYCLES = 3;
  localparam logic [1:0] SSO_ACCESS_LAST = 2'(SSO_ACCESS_CYCLES - 1);

  // axi response codes
  localparam logic [1:0] SSO_RESP_OKAY = 2'b00;
  localparam logic [1:0] SSO_RESP_SLVERR = 2'b10;
  localparam logic [1:0] SSO_RESP_DECERR = 2'b11;

  // command register layout, bit 2 down to bit 0
  typedef struct packed {
    logic digital_irq_enable;
    logic path_select;
    logic legacy_compat_mode;
  } sso_cmd_s;

  // status and mask layout, bit 1 down to bit 0
  typedef struct packed {
    logic digital_path_irq_flag;
    logic dac_path_irq_flag;
  } sso_stat_s;

endpackage

// ---- rtl/sso_speech_out.sv ----
/*
  speech sample output register bank: holding registers, conversion register,
  digital output register, status, mask, command and scratch, behind an
  axi4-lite slave, plus the alternating sample loaders and the interrupt.
  assumes: the second timer's divided clock, its interrupt level and the
  external sync arrive asynchronously and are sampled here; the converter and
  filter sit outside and read converter_data.
*/
`timescale 1ns/1ns
module sso_speech_out (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // asynchronous sample timing inputs
  input wire logic second_timer_clk,
  input wire logic second_timer_irq,
  input wire logic external_sample_sync,
  // sample outputs and interrupt
  output logic [sso_pkg::SSO_SAMPLE_W-1:0] converter_data,
  output logic [sso_pkg::SSO_DIG_W-1:0] digital_out,
  output logic irq
);
  import sso_pkg::*;

  typedef enum {WR_COLLECT, WR_WAIT, WR_RESP} sso_wr_e;
  typedef enum {RD_IDLE, RD_WAIT, RD_RESP} sso_rd_e;

  // merge a 16-bit register with the low two byte lanes of a write
  function automatic logic [15:0] sso_merge(input logic [15:0] old_v, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old_v;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [SSO_SAMPLE_W-1:0] hold_a_reg;
  logic [SSO_SAMPLE_W-1:0] hold_b_reg;
  logic [SSO_SAMPLE_W-1:0] conv_reg;
  logic [SSO_DIG_W-1:0] dig_a_reg;
  logic [SSO_DIG_W-1:0] dig_b_reg;
  logic [SSO_DIG_W-1:0] dig_out_reg;
  logic [SSO_SCRATCH_W-1:0] scratch_reg;
  sso_cmd_s cmd_reg;
  sso_stat_s stat_reg;
  sso_stat_s stat_next;
  sso_stat_s mask_reg;
  logic irq_reg;
  logic irq_next;
  logic dac_sel_reg;
  logic dig_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detection

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  logic [2:0] rise;
  logic [2:0] fall;

  // index 0 timer clock, 1 timer interrupt, 2 external sync; edges only read the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      sync1_reg <= {external_sample_sync, second_timer_irq, second_timer_clk};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // axi write path

  sso_wr_e wr_state_reg;
  logic [1:0] wr_cnt_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_hs;
  logic w_hs;
  logic aw_held_next;
  logic w_held_next;
  logic wr_commit;
  logic [7:0] wr_off;
  logic wr_in_region;
  logic wr_known;

  assign aw_hs = awvalid & awready_reg;
  assign w_hs = wvalid & wready_reg;
  assign aw_held_next = aw_held_reg | aw_hs;
  assign w_held_next = w_held_reg | w_hs;
  // register effects land on the edge where the answer rises
  assign wr_commit = (wr_state_reg == WR_WAIT) && (wr_cnt_reg == 2'd0) && wr_in_region && wr_known;

  // write decode on the captured address, word aligned
  assign wr_off = {aw_addr_q[7:2], 2'b00};
  assign wr_in_region = (aw_addr_q[31:8] == SSO_REGION_TAG);
  assign wr_known = (wr_off <= SSO_OFF_MASK);

  // address and data are taken in either order, then a fixed wait, then the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_COLLECT;
      wr_cnt_reg <= 2'd0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= SSO_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_addr_q <= awaddr;
      end
      if (w_hs) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      case (wr_state_reg)
        WR_COLLECT: begin
          aw_held_reg <= aw_held_next;
          w_held_reg <= w_held_next;
          awready_reg <= ~aw_held_next;
          wready_reg <= ~w_held_next;
          if (aw_held_next && w_held_next) begin
            wr_state_reg <= WR_WAIT;
            wr_cnt_reg <= SSO_ACCESS_LAST;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
          end
        end
        WR_WAIT: begin
          if (wr_cnt_reg == 2'd0) begin
            wr_state_reg <= WR_RESP;
            bvalid_reg <= 1'b1;
            bresp_reg <= !wr_in_region ? SSO_RESP_DECERR : (wr_known ? SSO_RESP_OKAY : SSO_RESP_SLVERR);
          end else begin
            wr_cnt_reg <= wr_cnt_reg - 2'd1;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state_reg <= WR_COLLECT;
            bvalid_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
          end
        end
        default: begin
          wr_state_reg <= WR_COLLECT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read path

  sso_rd_e rd_state_reg;
  logic [1:0] rd_cnt_reg;
  logic [31:0] ar_addr_q;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_hs;
  logic [7:0] rd_off;
  logic rd_in_region;
  logic rd_known;
  logic [15:0] rd_word;

  assign ar_hs = arvalid & arready_reg;
  assign rd_off = {ar_addr_q[7:2], 2'b00};
  assign rd_in_region = (ar_addr_q[31:8] == SSO_REGION_TAG);
  assign rd_known = (rd_off <= SSO_OFF_MASK);

  // read selection; narrow registers are zero-extended so reserved bits read zero
  assign rd_word =
    (rd_off == SSO_OFF_HOLD_A) ? {4'h0, hold_a_reg} :
    (rd_off == SSO_OFF_HOLD_B) ? {4'h0, hold_b_reg} :
    (rd_off == SSO_OFF_CONV) ? {4'h0, conv_reg} :
    (rd_off == SSO_OFF_STAT) ? {14'h0000, stat_reg} :
    (rd_off == SSO_OFF_SCRATCH) ? {14'h0000, scratch_reg} :
    (rd_off == SSO_OFF_CMD) ? {13'h0000, cmd_reg} :
    (rd_off == SSO_OFF_DIG_A) ? dig_a_reg :
    (rd_off == SSO_OFF_DIG_B) ? dig_b_reg :
    (rd_off == SSO_OFF_MASK) ? {14'h0000, mask_reg} :
    16'h0000;

  // one read at a time; data is sampled when the answer is raised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      rd_cnt_reg <= 2'd0;
      ar_addr_q <= 32'h0000_0000;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= SSO_RESP_OKAY;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          arready_reg <= 1'b1;
          if (ar_hs) begin
            ar_addr_q <= araddr;
            arready_reg <= 1'b0;
            rd_cnt_reg <= SSO_ACCESS_LAST;
            rd_state_reg <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (rd_cnt_reg == 2'd0) begin
            rd_state_reg <= RD_RESP;
            rvalid_reg <= 1'b1;
            rdata_reg <= (rd_in_region && rd_known) ? {16'h0000, rd_word} : 32'h0000_0000;
            rresp_reg <= !rd_in_region ? SSO_RESP_DECERR : (rd_known ? SSO_RESP_OKAY : SSO_RESP_SLVERR);
          end else begin
            rd_cnt_reg <= rd_cnt_reg - 2'd1;
          end
        end
        RD_RESP: begin
          if (rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software writes to the register bank

  logic wr_hold_a;
  logic wr_hold_b;
  logic wr_stat;
  logic wr_scratch;
  logic wr_cmd;
  logic wr_dig_a;
  logic wr_dig_b;
  logic wr_mask;
  logic [15:0] merge_hold_a;
  logic [15:0] merge_hold_b;
  logic [15:0] merge_scratch;
  logic [15:0] merge_cmd;
  logic [15:0] merge_mask;

  // the conversion register has no write strobe: writes to it are answered and dropped
  assign wr_hold_a = wr_commit && (wr_off == SSO_OFF_HOLD_A);
  assign wr_hold_b = wr_commit && (wr_off == SSO_OFF_HOLD_B);
  assign wr_stat = wr_commit && (wr_off == SSO_OFF_STAT) && w_strb_q[0];
  assign wr_scratch = wr_commit && (wr_off == SSO_OFF_SCRATCH);
  assign wr_cmd = wr_commit && (wr_off == SSO_OFF_CMD);
  assign wr_dig_a = wr_commit && (wr_off == SSO_OFF_DIG_A);
  assign wr_dig_b = wr_commit && (wr_off == SSO_OFF_DIG_B);
  assign wr_mask = wr_commit && (wr_off == SSO_OFF_MASK);

  assign merge_hold_a = sso_merge({4'h0, hold_a_reg}, w_data_q, w_strb_q);
  assign merge_hold_b = sso_merge({4'h0, hold_b_reg}, w_data_q, w_strb_q);
  assign merge_scratch = sso_merge({14'h0000, scratch_reg}, w_data_q, w_strb_q);
  assign merge_cmd = sso_merge({13'h0000, cmd_reg}, w_data_q, w_strb_q);
  assign merge_mask = sso_merge({14'h0000, mask_reg}, w_data_q, w_strb_q);

  // plain storage registers; upper bits are simply not kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_a_reg <= SSO_SAMPLE_RST;
      hold_b_reg <= SSO_SAMPLE_RST;
      scratch_reg <= SSO_SCRATCH_RST;
      cmd_reg <= SSO_CMD_RST;
      dig_a_reg <= SSO_DIG_RST;
      dig_b_reg <= SSO_DIG_RST;
      mask_reg <= SSO_MASK_RST;
    end else begin
      if (wr_hold_a) begin
        hold_a_reg <= merge_hold_a[11:0];
      end
      if (wr_hold_b) begin
        hold_b_reg <= merge_hold_b[11:0];
      end
      if (wr_scratch) begin
        scratch_reg <= merge_scratch[1:0];
      end
      if (wr_cmd) begin
        cmd_reg <= merge_cmd[2:0];
      end
      if (wr_dig_a) begin
        dig_a_reg <= sso_merge(dig_a_reg, w_data_q, w_strb_q);
      end
      if (wr_dig_b) begin
        dig_b_reg <= sso_merge(dig_b_reg, w_data_q, w_strb_q);
      end
      if (wr_mask) begin
        mask_reg <= merge_mask[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample loaders

  logic dac_tick;
  logic dig_tick;
  logic dac_pair_done;
  logic dig_pair_done;

  // the converter only moves on a timer clock edge, giving one step per period
  assign dac_tick = rise[0] & ~cmd_reg.path_select;
  assign dig_tick = rise[2] & cmd_reg.path_select;
  // a pair is consumed every second tick: that halves the interrupt rate
  assign dac_pair_done = dac_tick & dac_sel_reg;
  assign dig_pair_done = dig_tick & dig_sel_reg;

  // alternate a then b; software refills b before a, so b is always ready second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_reg <= SSO_SAMPLE_RST;
      dig_out_reg <= SSO_DIG_RST;
      dac_sel_reg <= 1'b0;
      dig_sel_reg <= 1'b0;
    end else begin
      if (dac_tick) begin
        conv_reg <= dac_sel_reg ? hold_b_reg : hold_a_reg;
        dac_sel_reg <= ~dac_sel_reg;
      end
      if (dig_tick) begin
        dig_out_reg <= dig_sel_reg ? dig_b_reg : dig_a_reg;
        dig_sel_reg <= ~dig_sel_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, mask and interrupt

  sso_stat_s stat_set;
  sso_stat_s stat_clr;

  // legacy mode mirrors the timer interrupt into the converter flag; otherwise, and always for the digital flag, the loaders raise events
  assign stat_set.dac_path_irq_flag = cmd_reg.legacy_compat_mode ? rise[1] : dac_pair_done;
  assign stat_set.digital_path_irq_flag = dig_pair_done & cmd_reg.digital_irq_enable;
  // a written zero clears its bit; legacy mode also clears all on the timer release
  assign stat_clr.dac_path_irq_flag = (wr_stat & ~w_data_q[0]) | (cmd_reg.legacy_compat_mode & fall[1]);
  assign stat_clr.digital_path_irq_flag = (wr_stat & ~w_data_q[1]) | (cmd_reg.legacy_compat_mode & fall[1]);
  // set wins over a clear in the same cycle so no event is lost
  assign stat_next = stat_set | (stat_reg & ~stat_clr);
  // legacy mode passes the timer interrupt straight out, bypassing the mask
  assign irq_next = cmd_reg.legacy_compat_mode ? sync2_reg[1] : |(stat_next & mask_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= SSO_STAT_RST;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign converter_data = conv_reg;
  assign digital_out = dig_out_reg;
  assign irq = irq_reg;

endmodule
